// file: test/ppci_pin_model.sv
// Behavioural model of the external logic driving the six port pins
`timescale 1ns/1ns

module ppci_pin_model (
	// Clock and wanted pin levels
	input wire logic clk_sys_in,
	input wire logic [5:0] level_in,
	// Pins towards the block
	output logic [5:0] port_a_pin_out
);
	// Pins move just after an edge, so each level lasts whole cycles and no edge is missed
	// One process starts the pins low and then follows the wanted levels
	initial begin
		port_a_pin_out = 6'h00;
		forever begin
			@(posedge clk_sys_in);
			port_a_pin_out <= level_in;
		end
	end
endmodule // ppci_pin_model

// file: test/testbench.sv
// Self-checking bench for the pin-change interrupt block
`timescale 1ns/1ns
`include "ppci_regs.svh"

module testbench;
	logic clk_sys_in, rst_in, rd, wr, sleep, ce;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [3:0] be;
	logic [5:0] level, pins;
	logic wreq, wake, chg_irq, irq, got;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;

	// Clock and a cycle ceiling against hangs
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			conclude();
		end
	end

	ppci_pin_model pin_model (.clk_sys_in(clk_sys_in), .level_in(level), .port_a_pin_out(pins));

	ppci_top DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .port_a_pin_in(pins),
		.sleep_in(sleep), .wake_out(wake), .change_irq_out(chg_irq), .irq_out(irq));

	task conclude();
		$display("comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus cycle; the request holds until waitrequest is seen low at a rising edge,
	// and read data is taken at that same edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge clk_sys_in);
		end while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	task pins_to(input logic [5:0] v);
		level <= v;
		repeat (8) @(posedge clk_sys_in);
	endtask

	initial begin
		{rd, wr, sleep, addr, wdata, level} <= '0;
		be <= 4'hF;
		ce <= 1'b1;
		rst_in <= 1'b1;
		repeat (12) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		// Reset values, unmapped place
		rd_chk(`PPCI_OFS_RISE, 32'h0);
		rd_chk(`PPCI_OFS_FALL, 32'h0);
		rd_chk(`PPCI_OFS_FLAGS, 32'h0);
		rd_chk(8'h20, 32'h0);
		// Enables keep bits 5..0 only
		bus(1'b1, `PPCI_OFS_RISE, 32'hFF);
		rd_chk(`PPCI_OFS_RISE, 32'h3F);
		bus(1'b1, `PPCI_OFS_FALL, 32'hFF);
		rd_chk(`PPCI_OFS_FALL, 32'h3F);
		// Rising armed on 0,2,4, falling on 1,3, pin 5 on neither
		bus(1'b1, `PPCI_OFS_RISE, 32'h15);
		bus(1'b1, `PPCI_OFS_FALL, 32'h0A);
		// Byte lane 0 off makes the write a no-op
		be <= 4'hE;
		bus(1'b1, `PPCI_OFS_RISE, 32'h3F);
		be <= 4'hF;
		rd_chk(`PPCI_OFS_RISE, 32'h15);
		pins_to(6'h3F);
		rd_chk(`PPCI_OFS_FLAGS, 32'h15);
		pins_to(6'h00);
		rd_chk(`PPCI_OFS_FLAGS, 32'h1F);
		check(chg_irq, 1'b0);
		rd_chk(`PPCI_OFS_CTRL, 32'h2);
		// Single-bit clear, then the read, invert and AND sequence
		bus(1'b1, `PPCI_OFS_FLAGS, 32'h1E);
		rd_chk(`PPCI_OFS_FLAGS, 32'h1E);
		bus(1'b1, `PPCI_OFS_FLAGS, (q ^ 32'hFF) & q);
		rd_chk(`PPCI_OFS_FLAGS, 32'h0);
		rd_chk(`PPCI_OFS_CTRL, 32'h0);
		// Both polarities on one pin
		bus(1'b1, `PPCI_OFS_RISE, 32'h20);
		bus(1'b1, `PPCI_OFS_FALL, 32'h20);
		pins_to(6'h20);
		rd_chk(`PPCI_OFS_FLAGS, 32'h20);
		bus(1'b1, `PPCI_OFS_FLAGS, 32'h0);
		pins_to(6'h00);
		rd_chk(`PPCI_OFS_FLAGS, 32'h20);
		// Sticky status, mask, write-one-to-clear
		rd_chk(`PPCI_OFS_IRQ_STATUS, 32'h1);
		check(irq, 1'b0);
		bus(1'b1, `PPCI_OFS_IRQ_MASK, 32'h1);
		@(posedge clk_sys_in);
		check(irq, 1'b1);
		bus(1'b1, `PPCI_OFS_IRQ_STATUS, 32'h1);
		rd_chk(`PPCI_OFS_IRQ_STATUS, 32'h0);
		check(irq, 1'b0);
		// Edge arriving while software clears the flags
		bus(1'b1, `PPCI_OFS_RISE, 32'h01);
		level <= 6'h01;
		// One cycle later the edge meets the accepted write in the same cycle
		@(posedge clk_sys_in);
		bus(1'b1, `PPCI_OFS_FLAGS, 32'h0);
		pins_to(6'h01);
		rd_chk(`PPCI_OFS_FLAGS, 32'h01);
		// Wake from sleep with the master enable set
		pins_to(6'h00);
		bus(1'b1, `PPCI_OFS_FLAGS, 32'h0);
		bus(1'b1, `PPCI_OFS_CTRL, 32'h1);
		sleep <= 1'b1;
		level <= 6'h01;
		got = 1'b0;
		repeat (10) begin
			@(posedge clk_sys_in);
			if (wake === 1'b1)
				got = 1'b1;
		end
		check(got, 1'b1);
		check(chg_irq, 1'b1);
		sleep <= 1'b0;
		rd_chk(`PPCI_OFS_FLAGS, 32'h01);
		rd_chk(`PPCI_OFS_IRQ_STATUS, 32'h3);
		// Clock enable low freezes detection until it returns
		pins_to(6'h00);
		bus(1'b1, `PPCI_OFS_FLAGS, 32'h0);
		ce <= 1'b0;
		pins_to(6'h01);
		check(chg_irq, 1'b0);
		ce <= 1'b1;
		pins_to(6'h01);
		check(chg_irq, 1'b1);
		conclude();
	end
endmodule // testbench

// file: verilog/ppci_pkg.sv
// Types shared by the pin-change interrupt block
package ppci_pkg;

	typedef logic [5:0] ppci_pins_t;
	typedef logic [1:0] ppci_irq_t;

	// Whole state of the block, registered in one process
	typedef struct packed {
		ppci_pins_t sync_first;
		ppci_pins_t sync_second;
		ppci_pins_t prev;
		ppci_pins_t rise_edge_enable;
		ppci_pins_t fall_edge_enable;
		ppci_pins_t pin_change_flags;
		logic change_irq_master_enable;
		ppci_irq_t irq_status;
		ppci_irq_t irq_mask;
		logic ack;
		logic [7:0] rdata;
		logic wake;
	} ppci_state_s;

endpackage

// file: verilog/ppci_regs.svh
// Register offsets, field positions and reset values of the pin-change interrupt block
`ifndef PPCI_REGS_SVH
`define PPCI_REGS_SVH

// Word-aligned byte offsets on the register bus
`define PPCI_OFS_RISE 8'h00
`define PPCI_OFS_FALL 8'h04
`define PPCI_OFS_FLAGS 8'h08
`define PPCI_OFS_CTRL 8'h0C
`define PPCI_OFS_IRQ_STATUS 8'h10
`define PPCI_OFS_IRQ_MASK 8'h14

// Field layout
`define PPCI_PIN_COUNT 6
`define PPCI_PIN_MSB 5
`define PPCI_CTRL_MASTER_EN_BIT 0
`define PPCI_CTRL_SUMMARY_BIT 1
`define PPCI_IRQ_EDGE_BIT 0
`define PPCI_IRQ_WAKE_BIT 1
`define PPCI_IRQ_MSB 1

// Reset values
`define PPCI_RST_PINS 6'h00
`define PPCI_RST_IRQ 2'h0
`define PPCI_RST_BYTE 8'h00

`endif

// file: verilog/ppci_top.sv
// Pin-change interrupt block for a six-pin port with an Avalon-MM register slave
//
// What this block does
// R1: Rising enable bits 5..0 arm rising detection.
// R2: Falling enable bits 5..0 arm falling detection.
// R3: Enabled edge of matching polarity sets pin flag.
// R4: Flag zero means unseen or cleared; per-bit clear.
// R5: Bits 7..6 of three registers read zero.
// R6: Software clears flags by read, invert, AND.
// R7: Master enable lets a detected edge wake device.
// R8: Flag recorded before first instruction after wake.
// R9: Detection continues with master enable clear.
// R10: Summary flag is OR of all pin flags.
// R11: Edge during clearing write leaves flag set.
// R12: Both enables flag edges of either polarity.
// R13: Synchronise pins, compare with previous sample.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "ppci_regs.svh"

module ppci_top
	import ppci_pkg::*;
(
	// Clock, reset and clock enable
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Port pins, asynchronous to the system clock
	input wire logic [5:0] port_a_pin_in,
	// Core sleep state and wake request
	input wire logic sleep_in,
	output logic wake_out,
	// Interrupt outputs
	output logic change_irq_out,
	output logic irq_out
);

	ppci_state_s q;
	ppci_state_s next_q;

	logic [5:0] rise_seen;
	logic [5:0] fall_seen;
	logic [5:0] hit;
	logic summary;
	logic bus_req;
	logic acc_wr;
	logic acc_rd;
	logic be_low;
	logic [7:0] rd_mux;
	logic [5:0] both_hit;

	// Edges come from the second sync stage against the stored previous sample
	// A pin pulse shorter than one clock period can slip between samples unseen
	assign rise_seen = q.sync_second & ~q.prev; // R13
	assign fall_seen = ~q.sync_second & q.prev; // R13

	// Each polarity is gated by its own enable, so both enables catch either edge
	assign hit = (rise_seen & q.rise_edge_enable) // R1 R3 R12
		| (fall_seen & q.fall_edge_enable); // R2 R3 R12

	// Pins armed for both polarities, watched by the either-edge check
	assign both_hit = q.rise_edge_enable & q.fall_edge_enable & (rise_seen | fall_seen); // R12

	// Summary flag never depends on the master enable
	assign summary = |q.pin_change_flags; // R10

	// Bus handshake: one wait cycle, answer on the second cycle of a request
	// Read data is snapshotted in the wait cycle, trading freshness for a registered output
	assign bus_req = avs_read_in | avs_write_in;
	assign acc_wr = avs_write_in & q.ack;
	assign acc_rd = avs_read_in & q.ack;
	assign be_low = avs_byteenable_in[0];
	assign avs_waitrequest_out = bus_req & ~q.ack;

	// Read multiplexer; unimplemented bits and unmapped offsets read zero
	always_comb begin
		rd_mux = `PPCI_RST_BYTE;
		case (avs_address_in)
			`PPCI_OFS_RISE: begin
				rd_mux = {2'h0, q.rise_edge_enable}; // R5
			end
			`PPCI_OFS_FALL: begin
				rd_mux = {2'h0, q.fall_edge_enable}; // R5
			end
			`PPCI_OFS_FLAGS: begin
				rd_mux = {2'h0, q.pin_change_flags}; // R5
			end
			`PPCI_OFS_CTRL: begin
				rd_mux = {6'h00, summary, q.change_irq_master_enable}; // R10
			end
			`PPCI_OFS_IRQ_STATUS: begin
				rd_mux = {6'h00, q.irq_status};
			end
			`PPCI_OFS_IRQ_MASK: begin
				rd_mux = {6'h00, q.irq_mask};
			end
			default: begin
				rd_mux = `PPCI_RST_BYTE;
			end
		endcase
	end

	// Next-state logic for the whole block
	always_comb begin
		next_q = q;
		// Two flops per pin before anything looks at it
		next_q.sync_first = port_a_pin_in; // R13
		next_q.sync_second = q.sync_first; // R13
		next_q.prev = q.sync_second; // R13

		// Request acknowledged one cycle after it appears, dropped after acceptance
		next_q.ack = bus_req & ~q.ack;
		if (bus_req && !q.ack) begin
			next_q.rdata = rd_mux;
		end

		// Configuration writes
		// Unmapped offsets and writes with byte lane 0 off are answered but change nothing
		if (acc_wr && be_low) begin
			case (avs_address_in)
				`PPCI_OFS_RISE: begin
					next_q.rise_edge_enable = avs_writedata_in[5:0]; // R1
				end
				`PPCI_OFS_FALL: begin
					next_q.fall_edge_enable = avs_writedata_in[5:0]; // R2
				end
				`PPCI_OFS_CTRL: begin
					next_q.change_irq_master_enable =
						avs_writedata_in[`PPCI_CTRL_MASTER_EN_BIT];
				end
				`PPCI_OFS_IRQ_MASK: begin
					next_q.irq_mask = avs_writedata_in[1:0];
				end
				default: begin
					next_q.irq_mask = q.irq_mask;
				end
			endcase
		end

		// Flag write stores the value, then a fresh edge is ORed on top so it wins
		if (acc_wr && be_low && avs_address_in == `PPCI_OFS_FLAGS) begin
			next_q.pin_change_flags = avs_writedata_in[5:0] | hit; // R4 R11
		end else begin
			next_q.pin_change_flags = q.pin_change_flags | hit; // R3 R9
		end

		// Sticky status bits: write one clears, a new event in the same cycle wins
		if (acc_wr && be_low && avs_address_in == `PPCI_OFS_IRQ_STATUS) begin
			next_q.irq_status = q.irq_status & ~avs_writedata_in[1:0];
		end
		if (|hit) begin
			next_q.irq_status[`PPCI_IRQ_EDGE_BIT] = 1'b1;
		end

		// Wake rises together with the flag update, so the flag is ready first
		next_q.wake = sleep_in & q.change_irq_master_enable & (|hit); // R7 R8
		if (sleep_in && q.change_irq_master_enable && (|hit)) begin
			next_q.irq_status[`PPCI_IRQ_WAKE_BIT] = 1'b1;
		end
	end

	// State register; clock enable low freezes everything
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			q.sync_first <= `PPCI_RST_PINS;
			q.sync_second <= `PPCI_RST_PINS;
			q.prev <= `PPCI_RST_PINS;
			q.rise_edge_enable <= `PPCI_RST_PINS;
			q.fall_edge_enable <= `PPCI_RST_PINS;
			q.pin_change_flags <= `PPCI_RST_PINS;
			q.change_irq_master_enable <= 1'b0;
			q.irq_status <= `PPCI_RST_IRQ;
			q.irq_mask <= `PPCI_RST_IRQ;
			q.ack <= 1'b0;
			q.rdata <= `PPCI_RST_BYTE;
			q.wake <= 1'b0;
		end else if (ce_in) begin
			q <= next_q;
		end
	end

	// Outputs
	assign avs_readdata_out = {24'h000000, q.rdata};
	assign wake_out = q.wake;
	// The request to the core is gated by the master enable, as is the wake; the flags are not
	assign change_irq_out = q.change_irq_master_enable & summary; // R9
	assign irq_out = |(q.irq_status & q.irq_mask);

	// Checks

	// Enabled rising edge always lands in the flags
	AST_RISE_SETS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R1
		(ce_in && |(rise_seen & q.rise_edge_enable))
		|=> ((q.pin_change_flags & $past(rise_seen & q.rise_edge_enable))
			== $past(rise_seen & q.rise_edge_enable)))
		else $error("enabled rising edge did not set its flag");

	// Enabled falling edge always lands in the flags
	AST_FALL_SETS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R2
		(ce_in && |(fall_seen & q.fall_edge_enable))
		|=> ((q.pin_change_flags & $past(fall_seen & q.fall_edge_enable))
			== $past(fall_seen & q.fall_edge_enable)))
		else $error("enabled falling edge did not set its flag");

	// Without an enabled edge or a flag write the flags hold
	AST_NO_SPURIOUS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R3
		(ce_in && hit == 6'h00 && !(acc_wr && avs_address_in == `PPCI_OFS_FLAGS))
		|=> $stable(q.pin_change_flags))
		else $error("flag changed without an enabled edge");

	// A clearing write with no edge leaves exactly the written value
	AST_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R4
		(ce_in && acc_wr && be_low && avs_address_in == `PPCI_OFS_FLAGS && hit == 6'h00)
		|=> (q.pin_change_flags == $past(avs_writedata_in[5:0])))
		else $error("flag write did not store the written value");

	// An edge during a clearing write wins
	AST_SET_WINS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R11
		(ce_in && acc_wr && avs_address_in == `PPCI_OFS_FLAGS && hit != 6'h00)
		|=> ((q.pin_change_flags & $past(hit)) == $past(hit)))
		else $error("edge lost during flag clear");

	// Bits 7..6 read zero on every accepted read
	AST_RSVD_ZERO: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R5
		(avs_read_in && !avs_waitrequest_out) |-> (avs_readdata_out[7:6] == 2'h0))
		else $error("unimplemented bits read nonzero");

	// Summary follows the flags and drives the core request only with master enable
	AST_SUMMARY: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R10
		change_irq_out |-> (q.change_irq_master_enable && q.pin_change_flags != 6'h00))
		else $error("core request without a set flag and master enable");

	// Master enable clear still records edges but raises no request on change_irq_out
	AST_MASTER_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R9
		(ce_in && !q.change_irq_master_enable && hit != 6'h00
			&& !(acc_wr && avs_address_in == `PPCI_OFS_CTRL))
		|=> (q.pin_change_flags != 6'h00 && !change_irq_out))
		else $error("detection or gating wrong with master enable clear");

	// Wake in sleep comes with the flag already set
	AST_WAKE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R7
		(ce_in && sleep_in && q.change_irq_master_enable && hit != 6'h00)
		|=> (wake_out && (q.pin_change_flags & $past(hit)) == $past(hit))) // R8
		else $error("wake missing or flag not recorded at wake");

	// Pin change reaches the edge compare after exactly two sync stages
	AST_SYNC: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R13
		(ce_in ##1 ce_in ##1 ce_in) |-> (q.sync_second == $past(port_a_pin_in, 2)))
		else $error("sync depth wrong");

	// Every request is answered after one wait cycle
	AST_WAIT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(ce_in && bus_req && avs_waitrequest_out) |=> (q.ack))
		else $error("bus request not acknowledged in time");

	// Ack drops after every acceptance, so back-to-back requests each wait once
	AST_ACK_DROP: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(ce_in && bus_req && !avs_waitrequest_out) |=> (!q.ack))
		else $error("bus acknowledge held past acceptance");

	// Accepted writes land in the enable registers, bits 5..0 only
	AST_RISE_WRITE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R1
		(ce_in && acc_wr && be_low && avs_address_in == `PPCI_OFS_RISE)
		|=> (q.rise_edge_enable == $past(avs_writedata_in[5:0])))
		else $error("rising enable write lost");

	// Same for the falling enables
	AST_FALL_WRITE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R2
		(ce_in && acc_wr && be_low && avs_address_in == `PPCI_OFS_FALL)
		|=> (q.fall_edge_enable == $past(avs_writedata_in[5:0])))
		else $error("falling enable write lost");

	// Byte lane 0 off turns a write into a no-op
	AST_LANE_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R1
		(ce_in && avs_write_in && !be_low && avs_address_in == `PPCI_OFS_RISE)
		|=> $stable(q.rise_edge_enable))
		else $error("write with byte lane 0 off changed an enable");

	// Master enable write lands
	AST_CTRL_WRITE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R7
		(ce_in && acc_wr && be_low && avs_address_in == `PPCI_OFS_CTRL)
		|=> (q.change_irq_master_enable
			== $past(avs_writedata_in[`PPCI_CTRL_MASTER_EN_BIT])))
		else $error("master enable write lost");

	// A flag only rises for an enabled edge of its own polarity
	AST_ONLY_ENABLED: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R3
		(ce_in && !(acc_wr && be_low && avs_address_in == `PPCI_OFS_FLAGS))
		|=> ((q.pin_change_flags & ~$past(q.pin_change_flags)
			& ~$past(rise_seen & q.rise_edge_enable)
			& ~$past(fall_seen & q.fall_edge_enable)) == 6'h00))
		else $error("flag set without an enabled edge");

	// Flags stay set until software writes the flag register
	AST_FLAG_STICKY: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R4
		(ce_in && !(acc_wr && be_low && avs_address_in == `PPCI_OFS_FLAGS))
		|=> ((q.pin_change_flags & $past(q.pin_change_flags))
			== $past(q.pin_change_flags)))
		else $error("flag lost without a flag write");

	// Both enables set: an edge of either polarity is recorded
	AST_BOTH_EDGES: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R12
		(ce_in && both_hit != 6'h00)
		|=> ((q.pin_change_flags & $past(both_hit)) == $past(both_hit)))
		else $error("edge lost on a pin armed for both polarities");

	// Control read shows the summary flag as it stood when the read began
	AST_SUMMARY_READ: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R10
		(ce_in && avs_read_in && avs_waitrequest_out && avs_address_in == `PPCI_OFS_CTRL)
		|=> (avs_readdata_out[`PPCI_CTRL_SUMMARY_BIT] == $past(|q.pin_change_flags)))
		else $error("summary bit does not match the flags");

	// Upper read lanes are always zero
	AST_UPPER_ZERO: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R5
		(avs_read_in && !avs_waitrequest_out) |-> (avs_readdata_out[31:8] == 24'h000000))
		else $error("upper read data lanes nonzero");

	// No wake without the master enable
	AST_NO_WAKE_OFF: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R7
		(ce_in && !q.change_irq_master_enable) |=> (!wake_out))
		else $error("wake raised with master enable clear");

	// A fresh wake always finds its flag already set
	AST_WAKE_FLAG: assert property (@(posedge clk_sys_in) disable iff (rst_in) // R8
		$rose(wake_out) |-> (q.pin_change_flags != 6'h00))
		else $error("wake raised before the flag was recorded");

	// Write one clears a status bit when no event competes
	AST_STATUS_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(ce_in && acc_wr && be_low && avs_address_in == `PPCI_OFS_IRQ_STATUS
			&& hit == 6'h00)
		|=> ((q.irq_status & $past(avs_writedata_in[1:0])) == 2'h0))
		else $error("status bit not cleared by a written one");

	// Clock enable low holds every state bit
	AST_FREEZE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(!ce_in && !rst_in) |=> $stable(q))
		else $error("state moved with clock enable low");

endmodule // ppci_top
